// ===== rtl/timer_pkg.sv
// constants shared by the 8-bit timer/event counter pair and its port pins
// assumes one byte-wide register port and a 200 MHz peripheral clock
package timer_pkg;
  localparam int NUM_CH   = 2;
  localparam int PRESC_W  = 12;
  localparam int SRC_W    = 3;

  // register byte addresses
  localparam logic [15:0] ADDR_PORT1_DIR   = 16'hff21;
  localparam logic [15:0] ADDR_PORT3_DIR   = 16'hff23;
  localparam logic [15:0] ADDR_PORT1_LATCH = 16'hff01;
  localparam logic [15:0] ADDR_PORT3_LATCH = 16'hff03;
  localparam logic [15:0] ADDR_MODE  [NUM_CH] = '{16'hff6b, 16'hff43};
  localparam logic [15:0] ADDR_MATCH [NUM_CH] = '{16'hff6d, 16'hff45};
  localparam logic [15:0] ADDR_COUNT [NUM_CH] = '{16'hff6c, 16'hff44};
  localparam logic [15:0] ADDR_SRC   [NUM_CH] = '{16'hff6e, 16'hff46};

  // reset values, and the fixed high nibble read back from the port 3 direction register
  localparam logic [7:0] PORT1_DIR_RST   = 8'hff;
  localparam logic [3:0] PORT3_DIR_RST   = 4'hf;
  localparam logic [3:0] PORT3_DIR_HIGH  = 4'hf;
  localparam logic [7:0] PORT_LATCH_RST  = 8'h00;
  localparam logic [7:0] MODE_RST        = 8'h00;
  localparam logic [7:0] MATCH_RST       = 8'h00;
  localparam logic [7:0] COUNT_RST       = 8'h00;
  localparam logic [2:0] SRC_RST         = 3'h0;

  // timer_mode_control field positions
  localparam int BIT_COUNT_EN = 7;
  localparam int BIT_PWM      = 6;
  localparam int BIT_FF_SET   = 3;
  localparam int BIT_FF_CLR   = 2;
  localparam int BIT_INV_LVL  = 1;
  localparam int BIT_OUT_EN   = 0;

  // count_source_select codes and prescaler masks per code
  localparam logic [2:0] SRC_PIN_FALL = 3'h0;
  localparam logic [2:0] SRC_PIN_RISE = 3'h1;
  localparam logic [PRESC_W-1:0] PRESC_MASK [8] = '{12'h000, 12'h000, 12'h000, 12'h001,
                                                    12'h00f, 12'h03f, 12'h0ff, 12'hfff};

  // pin assignment of the shared timer pins, and the count value at which PWM mode wraps
  localparam int PIN_CH0 = 7;
  localparam int PIN_CH1 = 3;
  localparam logic [7:0] PWM_TOP = 8'hff;
endpackage

// ===== rtl/edge_sync.sv
// two-stage synchroniser for an event pin with rise and fall detection
// assumes the pin is asynchronous to ref_clk_i
`timescale 1ns/10ps
module edge_sync (
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_s;

  sync_s state_r;
  sync_s state_nxt;

  always_comb begin
    state_nxt      = state_r;
    state_nxt.meta = pin_i;
    state_nxt.sync = state_r.meta;
    state_nxt.last = state_r.sync;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // pins start as inputs resting high, so no false edge follows reset
      state_r <= '1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one pulse per synchronised edge
  assign rise_o = state_r.sync & ~state_r.last;
  assign fall_o = ~state_r.sync & state_r.last;
endmodule

// ===== rtl/timer_event_pair.sv
// two 8-bit timer/event counters with their shared port pins and direction registers
// assumes a byte register port driven from ref_clk_i; pins are asynchronous
`timescale 1ns/10ps
module timer_event_pair (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [7:0]  port1_pin_i,
  output logic      [7:0]  port1_pin_o,
  output logic      [7:0]  port1_oe_o,
  input  wire logic [3:0]  port3_pin_i,
  output logic      [3:0]  port3_pin_o,
  output logic      [3:0]  port3_oe_o,
  output logic      [timer_pkg::NUM_CH-1:0] match_interrupt_o
);
  import timer_pkg::*;

  typedef struct packed {
    logic [7:0]       count;
    logic [7:0]       match_buf;
    logic [7:0]       match_act;
    logic [SRC_W-1:0] src;
    logic             count_en;
    logic             pwm_mode;
    logic             inv_lvl;
    logic             out_en;
    logic             out_ff;
    logic             pwm_run;
    logic             to_q;
    logic             irq;
  } chan_s;

  typedef struct packed {
    logic [7:0]         port1_dir;
    logic [3:0]         port3_dir;
    logic [7:0]         port1_latch;
    logic [3:0]         port3_latch;
    logic [PRESC_W-1:0] presc;
    logic [7:0]         rdata;
    chan_s [NUM_CH-1:0] ch;
  } top_s;

  top_s state_r;
  top_s state_nxt;

  logic [NUM_CH-1:0] pin_rise;
  logic [NUM_CH-1:0] pin_fall;
  logic [NUM_CH-1:0] event_pin;

  assign event_pin[0] = port1_pin_i[PIN_CH0];
  assign event_pin[1] = port3_pin_i[PIN_CH1];

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_sync
      edge_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (event_pin[g]),
        .rise_o    (pin_rise[g]),
        .fall_o    (pin_fall[g])
      );
    end
  endgenerate

  always_comb begin
    chan_s              c;
    logic               tick;
    logic               active;
    logic [PRESC_W-1:0] mask;
    c         = '0;
    tick      = 1'b0;
    active    = 1'b0;
    mask      = '0;
    state_nxt = state_r;
    // shared prescaler of the peripheral clock
    state_nxt.presc = state_r.presc + PRESC_W'(1);

    for (int i = 0; i < NUM_CH; i++) begin
      c     = state_r.ch[i];
      c.irq = 1'b0;
      mask  = PRESC_MASK[c.src];
      case (c.src)
        SRC_PIN_FALL: tick = pin_fall[i];
        SRC_PIN_RISE: tick = pin_rise[i];
        default:      tick = (state_r.presc & mask) == mask;
      endcase

      if (c.count_en) begin
        if (tick) begin
          if (c.pwm_mode) begin
            // free-running: wrap at the top, load buffered compare value
            if (c.count == PWM_TOP) begin
              c.count     = COUNT_RST;
              c.pwm_run   = 1'b1;
              c.match_act = c.match_buf;
            end else begin
              c.count = c.count + 8'h01;
            end
            if (state_r.ch[i].count == state_r.ch[i].match_act) begin
              c.irq = 1'b1;
            end
          end else if (c.count == c.match_act) begin
            c.count = COUNT_RST;
            c.irq   = 1'b1;
            if (c.inv_lvl) begin
              c.out_ff = ~c.out_ff;
            end
          end else begin
            c.count = c.count + 8'h01;
          end
        end
      end else begin
        c.count   = COUNT_RST;
        c.pwm_run = 1'b0;
      end

      if (reg_wr_i && reg_addr_i == ADDR_MODE[i]) begin
        c.count_en = reg_wdata_i[BIT_COUNT_EN];
        c.pwm_mode = reg_wdata_i[BIT_PWM];
        c.inv_lvl  = reg_wdata_i[BIT_INV_LVL];
        c.out_en   = reg_wdata_i[BIT_OUT_EN];
        if (!reg_wdata_i[BIT_COUNT_EN]) begin
          c.count   = COUNT_RST;
          c.pwm_run = 1'b0;
        end
        // flip-flop set/clear only outside PWM mode; both set is ignored
        if (!reg_wdata_i[BIT_PWM]) begin
          if (reg_wdata_i[BIT_FF_SET] && !reg_wdata_i[BIT_FF_CLR]) begin
            c.out_ff = 1'b1;
          end else if (reg_wdata_i[BIT_FF_CLR] && !reg_wdata_i[BIT_FF_SET]) begin
            c.out_ff = 1'b0;
          end
        end
      end
      if (reg_wr_i && reg_addr_i == ADDR_MATCH[i]) begin
        c.match_buf = reg_wdata_i;
        // a running PWM channel takes the new value at the next wrap
        if (!(c.pwm_mode && c.count_en)) begin
          c.match_act = reg_wdata_i;
        end
      end
      if (reg_wr_i && reg_addr_i == ADDR_SRC[i]) begin
        c.src = reg_wdata_i[SRC_W-1:0];
      end

      active = c.pwm_run && (c.count < c.match_act);
      if (!c.out_en) begin
        c.to_q = 1'b0;
      end else if (c.pwm_mode) begin
        c.to_q = active ^ c.inv_lvl;
      end else begin
        c.to_q = c.out_ff;
      end
      state_nxt.ch[i] = c;
    end

    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_PORT1_DIR:   state_nxt.port1_dir   = reg_wdata_i;
        ADDR_PORT3_DIR:   state_nxt.port3_dir   = reg_wdata_i[3:0];
        ADDR_PORT1_LATCH: state_nxt.port1_latch = reg_wdata_i;
        ADDR_PORT3_LATCH: state_nxt.port3_latch = reg_wdata_i[3:0];
        default: ;
      endcase
    end

    // read data is captured one edge after the strobe and then held
    if (reg_rd_i) begin
      state_nxt.rdata = 8'h00;
      case (reg_addr_i)
        ADDR_PORT1_DIR:   state_nxt.rdata = state_r.port1_dir;
        ADDR_PORT3_DIR:   state_nxt.rdata = {PORT3_DIR_HIGH, state_r.port3_dir};
        ADDR_PORT1_LATCH: state_nxt.rdata = state_r.port1_latch;
        ADDR_PORT3_LATCH: state_nxt.rdata = {4'h0, state_r.port3_latch};
        default: ;
      endcase
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_addr_i == ADDR_MODE[i]) begin
          // set/clear bits always read back as zero
          state_nxt.rdata = {state_r.ch[i].count_en, state_r.ch[i].pwm_mode, 4'h0,
                             state_r.ch[i].inv_lvl, state_r.ch[i].out_en};
        end
        if (reg_addr_i == ADDR_MATCH[i]) begin
          state_nxt.rdata = state_r.ch[i].match_buf;
        end
        if (reg_addr_i == ADDR_COUNT[i]) begin
          state_nxt.rdata = state_r.ch[i].count;
        end
        if (reg_addr_i == ADDR_SRC[i]) begin
          state_nxt.rdata = {5'h00, state_r.ch[i].src};
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r             <= '0;
      state_r.port1_dir   <= PORT1_DIR_RST;
      state_r.port3_dir   <= PORT3_DIR_RST;
      state_r.port1_latch <= PORT_LATCH_RST;
      state_r.port3_latch <= PORT_LATCH_RST[3:0];
      for (int i = 0; i < NUM_CH; i++) begin
        state_r.ch[i].match_buf <= MATCH_RST;
        state_r.ch[i].match_act <= MATCH_RST;
        state_r.ch[i].src       <= SRC_RST;
      end
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata_o = state_r.rdata;

  // pin drive: timer output is merged with the port latch on its shared pin
  generate
    for (g = 0; g < 8; g++) begin : g_port1
      assign port1_oe_o[g] = ~state_r.port1_dir[g];
      if (g == PIN_CH0) begin : g_to
        assign port1_pin_o[g] = state_r.port1_latch[g] | state_r.ch[0].to_q;
      end else begin : g_plain
        assign port1_pin_o[g] = state_r.port1_latch[g];
      end
    end
    for (g = 0; g < 4; g++) begin : g_port3
      assign port3_oe_o[g] = ~state_r.port3_dir[g];
      if (g == PIN_CH1) begin : g_to
        assign port3_pin_o[g] = state_r.port3_latch[g] | state_r.ch[1].to_q;
      end else begin : g_plain
        assign port3_pin_o[g] = state_r.port3_latch[g];
      end
    end
    for (g = 0; g < NUM_CH; g++) begin : g_irq
      assign match_interrupt_o[g] = state_r.ch[g].irq;
    end
  endgenerate
endmodule

// ===== verif/timer_event_pair_asserts.sv
// port assertions for the timer pair, bound into every instance of it
// assumes channel 0 drives port 1 bit 7 and one clock domain
`timescale 1ns/10ps
module timer_event_pair_asserts (
  input wire logic                         ref_clk_i,
  input wire logic                         rstn_i,
  input wire logic [15:0]                  reg_addr_i,
  input wire logic                         reg_wr_i,
  input wire logic [7:0]                   reg_wdata_i,
  input wire logic [7:0]                   port1_pin_o,
  input wire logic [7:0]                   port1_oe_o,
  input wire logic [3:0]                   port3_oe_o,
  input wire logic [timer_pkg::NUM_CH-1:0] match_interrupt_o
);
  import timer_pkg::*;
  logic [7:0] mode0_r;
  logic       lat7_r;
  logic       en0;
  logic       wr0;
  logic       sq0;
  assign en0 = mode0_r[7];
  assign wr0 = reg_wr_i && reg_addr_i == ADDR_MODE[0];
  assign sq0 = en0 && !mode0_r[6] && mode0_r[1] && mode0_r[0] && !lat7_r;
  // shadow of what software last wrote to channel 0 mode and pin latch
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode0_r <= 8'h00;
      lat7_r  <= 1'b0;
    end else begin
      if (wr0)
        mode0_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == ADDR_PORT1_LATCH)
        lat7_r <= reg_wdata_i[7];
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  chk_reset_inputs: assert property (!$past(rstn_i) |-> port1_oe_o == 8'h00 && port3_oe_o == 4'h0)
    else $error("pins not all inputs after reset");
  chk_dir1_drive: assert property (reg_wr_i && reg_addr_i == ADDR_PORT1_DIR |=> port1_oe_o == ~$past(reg_wdata_i))
    else $error("port 1 enables do not follow direction");
  chk_dir3_drive: assert property (reg_wr_i && reg_addr_i == ADDR_PORT3_DIR
    |=> {4'hf, port3_oe_o} == (~$past(reg_wdata_i) | 8'hf0))
    else $error("port 3 enables do not follow direction");
  chk_stop_quiet: assert property (!en0 && !$past(en0) |-> !match_interrupt_o[0])
    else $error("match while stopped");
  chk_out_off: assert property (wr0 && !reg_wdata_i[0] && !lat7_r |=> !port1_pin_o[7])
    else $error("timer output high while disabled");
  chk_pwm_stop: assert property (wr0 && en0 && mode0_r[6] && reg_wdata_i[7:6] == 2'b01 && reg_wdata_i[0] && !lat7_r
    |=> port1_pin_o[7] == mode0_r[1])
    else $error("pwm output not inactive after stop");
  chk_pwm_idle: assert property (wr0 && !en0 && reg_wdata_i[7:6] == 2'b11 && reg_wdata_i[0] && !lat7_r
    |=> (port1_pin_o[7] == mode0_r[1]) [*8])
    else $error("pwm output active before overflow");
  chk_sq_toggle: assert property (match_interrupt_o[0] && sq0 && $past(sq0)
    |-> port1_pin_o[7] != $past(port1_pin_o[7]))
    else $error("square wave did not toggle on match");
  cov_irq0: cover property (match_interrupt_o[0]);
  cov_irq1: cover property (match_interrupt_o[1]);
  cov_pwm: cover property (mode0_r[6] && $rose(port1_pin_o[7]));
endmodule

bind timer_event_pair timer_event_pair_asserts u_asserts (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .port1_pin_o(port1_pin_o),
  .port1_oe_o(port1_oe_o), .port3_oe_o(port3_oe_o), .match_interrupt_o(match_interrupt_o));

// ===== verif/event_source.sv
// pulse source on a timer event pin; pulled up whenever nobody drives it
// assumes the bench raises go_i for one cycle while busy_o is low
`timescale 1ns/10ps
module event_source (
  input  wire logic       ref_clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] count_i,
  input  wire logic [3:0] half_i,
  input  wire logic       oe_i,
  input  wire logic       drv_i,
  output logic            pin_o,
  output logic            busy_o
);
  logic lvl_r = 1'b1;
  initial busy_o = 1'b0;
  // each pulse is one fall and one rise, half_i cycles on each side
  always begin
    @(posedge ref_clk_i iff go_i);
    #1 busy_o = 1'b1;
    for (int i = 0; i < count_i; i++) begin
      repeat (half_i) @(posedge ref_clk_i);
      #1 lvl_r = 1'b0;
      repeat (half_i) @(posedge ref_clk_i);
      #1 lvl_r = 1'b1;
    end
    busy_o = 1'b0;
  end
  assign pin_o = oe_i ? drv_i : lvl_r;
endmodule

// ===== verif/timer_event_pair_tb_top.sv
// self-checking bench for the timer pair through its byte register port
// assumes the checker binds itself; pulse source sits on channel 1 pin
`timescale 1ns/10ps
module timer_event_pair_tb_top;
  import timer_pkg::*;
  logic              ref_clk_i = 1'b0;
  logic              rstn_i = 1'b0;
  logic [15:0]       reg_addr_i = 16'h0000;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [7:0]        reg_wdata_i = 8'h00;
  logic [7:0]        reg_rdata_o, port1_pin_i, port1_pin_o, port1_oe_o;
  logic [3:0]        port3_pin_i, port3_pin_o, port3_oe_o, src_half;
  logic [NUM_CH-1:0] match_interrupt_o;
  logic              src_pin, src_busy, src_go = 1'b0;
  int                num_errors = 0, samples_checked = 0, cycles = 0, n, k;
  int itab [5][3] = '{'{2, 3, 4}, '{2, 1, 2}, '{2, 255, 256}, '{3, 1, 4}, '{4, 1, 32}};
  // undriven pins read high through their pull-ups
  assign port1_pin_i = (port1_oe_o & port1_pin_o) | ~port1_oe_o;
  assign port3_pin_i = {src_pin, (port3_oe_o[2:0] & port3_pin_o[2:0]) | ~port3_oe_o[2:0]};
  timer_event_pair DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .port1_pin_i(port1_pin_i),
    .port1_pin_o(port1_pin_o), .port1_oe_o(port1_oe_o), .port3_pin_i(port3_pin_i), .port3_pin_o(port3_pin_o),
    .port3_oe_o(port3_oe_o), .match_interrupt_o(match_interrupt_o));
  event_source u_src (.ref_clk_i(ref_clk_i), .go_i(src_go), .count_i(8'h05), .half_i(src_half),
    .oe_i(port3_oe_o[3]), .drv_i(port3_pin_o[3]), .pin_o(src_pin), .busy_o(src_busy));
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1 reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge ref_clk_i);
    #1 reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
    @(posedge ref_clk_i);
    #1 reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge ref_clk_i);
    #1 reg_rd_i = 1'b0;
    chk(name, 16'(reg_rdata_o), 16'(exp));
  endtask
  // cycles until the watched output reaches v, capped at 3000
  task automatic wait_for(input int ch, input logic v, output int t);
    t = 0;
    do begin
      @(posedge ref_clk_i);
      #1 t++;
    end while ((ch < 0 ? port1_pin_o[7] : match_interrupt_o[ch]) !== v && t < 3000);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    src_half = 4'h2;
    repeat (8) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    rd(ADDR_PORT1_DIR, 8'hff, "dir1 reset");
    rd(ADDR_PORT3_DIR, 8'hff, "dir3 reset");
    rd(16'h0000, 8'h00, "unmapped");
    wr(ADDR_PORT1_DIR, 8'h5a);
    chk("oe1", 16'(port1_oe_o), 16'h00a5);
    wr(ADDR_PORT3_DIR, 8'h06);
    chk("oe3", 16'(port3_oe_o), 16'h0009);
    wr(ADDR_PORT1_LATCH, 8'h3c);
    chk("pin1", 16'(port1_pin_o), 16'h003c);
    wr(ADDR_PORT3_LATCH, 8'h05);
    chk("pin3", 16'(port3_pin_o), 16'h0005);
    rd(ADDR_PORT3_LATCH, 8'h05, "latch3");
    for (int c = 0; c < NUM_CH; c++)
      foreach (itab[i]) begin
        wr(ADDR_SRC[c], 8'(itab[i][0]));
        wr(ADDR_MATCH[c], 8'(itab[i][1]));
        wr(ADDR_MODE[c], 8'h80);
        wait_for(c, 1'b1, n);
        wait_for(c, 1'b1, n);
        chk("irq period", 16'(n), 16'(itab[i][2]));
        wr(ADDR_MODE[c], 8'h00);
        rd(ADDR_COUNT[c], 8'h00, "count stop");
      end
    wr(ADDR_PORT3_DIR, 8'hff);
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_MODE[1], 8'h00);
      wr(ADDR_SRC[1], 8'(e));
      wr(ADDR_MATCH[1], 8'h02);
      wr(ADDR_MODE[1], 8'h80);
      src_half = e ? 4'h6 : 4'h2;
      src_go = 1'b1;
      @(posedge ref_clk_i);
      #1 src_go = 1'b0;
      @(posedge ref_clk_i);
      n = 0;
      for (k = 0; src_busy !== 1'b0 && k < 3000; k++) begin
        @(posedge ref_clk_i);
        #1 if (match_interrupt_o[1] === 1'b1)
          n++;
      end
      repeat (4) @(posedge ref_clk_i);
      chk("event irq", 16'(n), 16'h0001);
      rd(ADDR_COUNT[1], 8'h02, "event count");
    end
    wr(ADDR_PORT1_DIR, 8'h7f);
    wr(ADDR_PORT1_LATCH, 8'h00);
    wr(ADDR_MATCH[0], 8'h02);
    wr(ADDR_SRC[0], 8'h02);
    for (int l = 0; l < 2; l++) begin
      wr(ADDR_MODE[0], l ? 8'h07 : 8'h0b);
      chk("sq start", 16'(port1_pin_o[7]), 16'(!l));
      wr(ADDR_MODE[0], 8'h83);
      wait_for(-1, 1'(l), n);
      wait_for(-1, 1'(!l), n);
      chk("sq half", 16'(n), 16'h0003);
      wr(ADDR_MODE[0], 8'h00);
    end
    wr(ADDR_MATCH[0], 8'h40);
    for (int l = 0; l < 2; l++) begin
      wr(ADDR_MODE[0], 8'h41 | 8'(l << 1));
      wr(ADDR_MODE[0], 8'hc1 | 8'(l << 1));
      wait_for(-1, 1'(!l), n);
      wait_for(-1, 1'(l), n);
      chk("pwm width", 16'(n), 16'h0040);
      wait_for(-1, 1'(!l), n);
      chk("pwm gap", 16'(n), 16'h00c0);
      wr(ADDR_MODE[0], 8'h41 | 8'(l << 1));
      chk("pwm stop", 16'(port1_pin_o[7]), 16'(l));
    end
    wr(ADDR_MODE[0], 8'hc0);
    wait_for(-1, 1'b1, n);
    chk("pwm off", 16'(n), 16'd3000);
    summarize();
  end
endmodule
